// >>> common/irq_vec_pkg.sv
// Purpose: Shared constants for the interrupt vector and status block
// Assumes: 64 interrupt sources, 32-bit Avalon-MM register port
// Notes:   Offsets are byte addresses on the register port
package irq_vec_pkg;

    // ********************************
    // Register offsets (byte address)
    // ********************************
    localparam logic [9:0] OFS_VEC_USB = 10'h230;
    localparam logic [9:0] OFS_VEC_TIMER = 10'h234;
    localparam logic [9:0] OFS_VEC_AUDIO = 10'h238;
    localparam logic [9:0] OFS_VEC_GPIO = 10'h23C;
    localparam logic [9:0] OFS_ISR_A_LO = 10'h300;
    localparam logic [9:0] OFS_ISR_A_HI = 10'h304;
    localparam logic [9:0] OFS_ISR_B_LO = 10'h320;
    localparam logic [9:0] OFS_ISR_B_HI = 10'h324;
    localparam logic [9:0] OFS_REQ_LO = 10'h380;
    localparam logic [9:0] OFS_REQ_HI = 10'h384;
    localparam logic [9:0] OFS_ISR_LO = 10'h3A0;
    localparam logic [9:0] OFS_ISR_HI = 10'h3A4;
    localparam logic [9:0] OFS_POL_LO = 10'h3E0;
    localparam logic [9:0] OFS_POL_HI = 10'h3E4;
    localparam logic [9:0] OFS_CTRL = 10'h3F0;

    // ********************************
    // Reset values
    // ********************************
    localparam logic [31:0] RST_VEC_USB = 32'h53525150;
    localparam logic [31:0] RST_VEC_TIMER = 32'h57565554;
    localparam logic [31:0] RST_VEC_AUDIO = 32'h5B5A5958;
    localparam logic [31:0] RST_VEC_GPIO = 32'h5F5E5D5C;
    localparam logic [63:0] RST_POL = 64'h0;
    localparam logic [1:0] RST_CTRL = 2'h0;

    // ********************************
    // Fields and source map
    // ********************************
    localparam int CTRL_MSG_MODE = 0;
    localparam int CTRL_GPIO_EDGE = 1;
    // First source that owns a vector here; the 16 vectors cover 48..63
    localparam int VEC_FIRST_SRC = 48;
    localparam int SRC_UPPER_PINS = 59;
    localparam int UPPER_PIN_COUNT = 53;
    localparam logic [63:0] DMA_MASK = 64'h0300_0000_0000_0000;
    localparam logic [63:0] GPIO_MASK = 64'hF800_0000_0000_0000;
    // Vector base for sources whose vectors live elsewhere
    localparam logic [7:0] OTHER_VEC_BASE = 8'h00;

    typedef enum logic [1:0] {
        MSG_IDLE = 2'b00,
        MSG_SEND = 2'b01
    } msg_state_t;

endpackage

// >>> design/irq_vector_status.sv
// Purpose: Interrupt vectors, request, in-service and polarity vectors
// Assumes: Requests and routing are synchronous to core_clk
// Notes:   One wait state on every bus access, no interrupt of its own;
//          sources below 48 send their own index as the vector
// Notes on behaviour
// RL1: Vectored sources have writable vector bytes, timer in the top lane.
// RL2: Each low GPIO group has its own vector byte, group three highest.
// RL3: All upper GPIO lines share one vector through one request bit.
// RL4: Output A in-service shows requested sources routed to A, two words.
// RL5: Output B in-service shows requested sources routed to B, two words.
// RL6: The 64-bit request vector reads as two words and resets to zero.
// RL7: The combined in-service vector covers both outputs and resets to zero.
// RL8: A writable polarity vector picks the active level of each source.
// RL9: In fixed mode software routes each source one-hot to one output.
// RL10: In line mode a pin stays low while a source routed to it is pending.
// RL11: In message mode a newly raised source sends its vector to the HT side.
// RL12: Audio DMA is edge, GPIO is level or edge, all else level active high.
// RL13: A per-output in-service bit needs a request and a route to it.
//
// The Avalon-MM slave port was decided locally.
`timescale 1ns/10ps
module irq_vector_status
    import irq_vec_pkg::*;
(
    input wire logic core_clk,                // 200 MHz clock
    input wire logic rst_n,                   // Async reset, active low
    input wire logic [9:0] address,           // Avalon byte address
    input wire logic read,                    // Avalon read
    input wire logic write,                   // Avalon write
    input wire logic [31:0] writedata,        // Avalon write data
    input wire logic [3:0] byteenable,        // Avalon byte enables
    output logic [31:0] readdata,             // Avalon read data
    output logic waitrequest,                 // Avalon wait
    input wire logic [63:0] srcReq,           // Raw source requests
    input wire logic [52:0] upperPins,        // Upper GPIO line requests
    input wire logic [63:0] routeA,           // Sources routed to out A
    input wire logic [63:0] routeB,           // Sources routed to out B
    output logic irq_out_a_n,                 // Line interrupt A, low
    output logic irq_out_b_n,                 // Line interrupt B, low
    output logic msgValid,                    // Message packet valid
    output logic [7:0] msgVector,             // Vector of the message
    input wire logic msgReady                 // HT side takes message
);

    // ********************************
    // State
    // ********************************
    // One packed word for all state keeps reset and update together
    typedef struct packed {
        logic [3:0][31:0] vec;
        logic [63:0] pol;
        logic [1:0] ctrl;
        logic [63:0] lvlPrev;
        logic [63:0] req;
        logic [63:0] isrA;
        logic [63:0] isrB;
        logic [63:0] pend;
        msg_state_t msgState;
        logic [7:0] msgVec;
        logic irqA;
        logic irqB;
        logic ack;
        logic [31:0] rdata;
    } state_t;

    state_t cur;
    state_t next_cur;

    // ********************************
    // Helpers
    // ********************************
    function automatic logic [31:0] merge_bytes(
        input logic [31:0] old,
        input logic [31:0] data,
        input logic [3:0] be
    );
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                res[8*b +: 8] = data[8*b +: 8];
            end
        end
        return res;
    endfunction

    function automatic logic [31:0] be_mask(input logic [3:0] be);
        logic [31:0] m;
        m = 32'h0;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                m[8*b +: 8] = 8'hFF;
            end
        end
        return m;
    endfunction

    // Vector of a source; sources below the vectored range use a base
    function automatic logic [7:0] vector_of(
        input logic [3:0][31:0] vec,
        input logic [5:0] idx
    );
        logic [5:0] rel;
        rel = idx - 6'(VEC_FIRST_SRC);
        if (idx >= 6'(VEC_FIRST_SRC)) begin
            vector_of = vec[rel[3:2]][8*rel[1:0] +: 8];
        end else begin
            vector_of = OTHER_VEC_BASE + {2'h0, idx};
        end
    endfunction

    // ********************************
    // Picker for pending messages
    // ********************************
    logic pickFound;
    logic [5:0] pickIndex;
    logic [63:0] pickOnehot;

    lowest_set_pick picker (
        .pending(cur.pend),
        .found(pickFound),
        .index(pickIndex),
        .onehot(pickOnehot)
    );

    // ********************************
    // Combinational next state
    // ********************************
    logic busReq;
    logic doWrite;
    logic doRead;
    logic [63:0] srcAll;
    logic [63:0] active;
    logic [63:0] rise;
    logic [63:0] edgeMask;
    logic [63:0] clearMask;
    logic [63:0] reqNext;
    logic [63:0] newRaise;

    // ********************************
    // Bus handshake
    // ********************************
    assign busReq = read | write;
    assign doWrite = write & ~cur.ack;
    assign doRead = read & ~cur.ack;
    // Answer on the edge after the request is first seen
    assign waitrequest = busReq & ~cur.ack;

    always_comb begin
        next_cur = cur;

        // ********************************
        // Source conditioning
        // ********************************
        // RL3: upper pins share one
        srcAll = srcReq;
        srcAll[SRC_UPPER_PINS] = srcReq[SRC_UPPER_PINS] | (|upperPins);

        // RL8: polarity picks level
        active = srcAll ^ cur.pol;
        // Rise only counts where the edge mask below selects it
        rise = active & ~cur.lvlPrev;

        // RL12: edge versus level
        edgeMask = DMA_MASK;
        if (cur.ctrl[CTRL_GPIO_EDGE]) begin
            edgeMask = edgeMask | GPIO_MASK;
        end

        // ********************************
        // Request and in-service
        // ********************************
        // Edge bits clear by writing one to the high request word
        // Only the high word holds edge sources, so only it clears
        clearMask = 64'h0;
        if (doWrite && address == OFS_REQ_HI) begin
            clearMask = {writedata & be_mask(byteenable), 32'h0};
        end

        // RL6: request vector update
        // Set beats clear so a rise during the clear is kept
        reqNext = (active & ~edgeMask)
                | (((cur.req & ~clearMask) | rise) & edgeMask);
        newRaise = reqNext & ~cur.req;
        next_cur.req = reqNext;
        next_cur.lvlPrev = active;

        // RL13: in-service needs request and route
        // RL9: relies on one-hot routing
        // Overlapping routes would light both views at once
        next_cur.isrA = reqNext & routeA;
        next_cur.isrB = reqNext & routeB;

        // RL10: line pins low while pending
        next_cur.irqA = ~cur.ctrl[CTRL_MSG_MODE] & (|next_cur.isrA);
        next_cur.irqB = ~cur.ctrl[CTRL_MSG_MODE] & (|next_cur.isrB);

        // ********************************
        // Message sender
        // ********************************
        // RL11: message for a new raise
        // Fixed priority: a busy low source can hold off higher ones
        case (cur.msgState)
            MSG_IDLE: begin
                if (pickFound) begin
                    next_cur.msgState = MSG_SEND;
                    next_cur.msgVec = vector_of(cur.vec, pickIndex);
                    next_cur.pend = cur.pend & ~pickOnehot;
                end
            end
            MSG_SEND: begin
                if (msgReady) begin
                    next_cur.msgState = MSG_IDLE;
                end
            end
            // Unused codes fall back to idle
            default: begin
                next_cur.msgState = MSG_IDLE;
            end
        endcase
        // Raises seen in line mode are dropped, not queued for later
        if (cur.ctrl[CTRL_MSG_MODE]) begin
            next_cur.pend = next_cur.pend | newRaise;
        end

        // ********************************
        // Register writes
        // ********************************
        // One wait state on every access lets read data come from a flop
        next_cur.ack = busReq & ~cur.ack;
        if (doWrite) begin
            // RL1: vector words, timer on top
            // RL2: low GPIO groups own bytes
            if (address == OFS_VEC_USB) begin
                next_cur.vec[0] = merge_bytes(cur.vec[0], writedata,
                                              byteenable);
            end else if (address == OFS_VEC_TIMER) begin
                next_cur.vec[1] = merge_bytes(cur.vec[1], writedata,
                                              byteenable);
            end else if (address == OFS_VEC_AUDIO) begin
                next_cur.vec[2] = merge_bytes(cur.vec[2], writedata,
                                              byteenable);
            end else if (address == OFS_VEC_GPIO) begin
                next_cur.vec[3] = merge_bytes(cur.vec[3], writedata,
                                              byteenable);
            end else if (address == OFS_POL_LO) begin
                // RL8: polarity low word
                next_cur.pol[31:0] = merge_bytes(cur.pol[31:0], writedata,
                                                 byteenable);
            end else if (address == OFS_POL_HI) begin
                next_cur.pol[63:32] = merge_bytes(cur.pol[63:32],
                                                  writedata, byteenable);
            end else if (address == OFS_CTRL) begin
                // Control bits sit in byte lane 0 only
                if (byteenable[0]) begin
                    next_cur.ctrl = writedata[1:0];
                end
            end else begin
                // Other offsets ignore writes here; a write to OFS_REQ_HI clears edge bits above
            end
        end

        // ********************************
        // Register reads
        // ********************************
        if (doRead) begin
            if (address == OFS_VEC_USB) begin
                next_cur.rdata = cur.vec[0];
            end else if (address == OFS_VEC_TIMER) begin
                next_cur.rdata = cur.vec[1];
            end else if (address == OFS_VEC_AUDIO) begin
                next_cur.rdata = cur.vec[2];
            end else if (address == OFS_VEC_GPIO) begin
                next_cur.rdata = cur.vec[3];
            end else if (address == OFS_ISR_A_LO) begin
                // RL4: output A in-service
                next_cur.rdata = cur.isrA[31:0];
            end else if (address == OFS_ISR_A_HI) begin
                next_cur.rdata = cur.isrA[63:32];
            end else if (address == OFS_ISR_B_LO) begin
                // RL5: output B in-service
                next_cur.rdata = cur.isrB[31:0];
            end else if (address == OFS_ISR_B_HI) begin
                next_cur.rdata = cur.isrB[63:32];
            end else if (address == OFS_REQ_LO) begin
                // RL6: request words
                next_cur.rdata = cur.req[31:0];
            end else if (address == OFS_REQ_HI) begin
                next_cur.rdata = cur.req[63:32];
            end else if (address == OFS_ISR_LO) begin
                // RL7: combined in-service
                // Derived from A and B, so the three views always agree
                next_cur.rdata = cur.isrA[31:0] | cur.isrB[31:0];
            end else if (address == OFS_ISR_HI) begin
                next_cur.rdata = cur.isrA[63:32] | cur.isrB[63:32];
            end else if (address == OFS_POL_LO) begin
                next_cur.rdata = cur.pol[31:0];
            end else if (address == OFS_POL_HI) begin
                next_cur.rdata = cur.pol[63:32];
            end else if (address == OFS_CTRL) begin
                next_cur.rdata = {30'h0, cur.ctrl};
            end else begin
                // Unmapped reads return zero
                next_cur.rdata = 32'h0;
            end
        end
    end

    // ********************************
    // Registers
    // ********************************
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            // Distinct vectors from reset let a host tell sources apart
            cur.vec[0] <= RST_VEC_USB;
            cur.vec[1] <= RST_VEC_TIMER;
            cur.vec[2] <= RST_VEC_AUDIO;
            cur.vec[3] <= RST_VEC_GPIO;
            cur.pol <= RST_POL;
            cur.ctrl <= RST_CTRL;
            // Starting at zero means a source already high at release
            // counts as a fresh rise
            cur.lvlPrev <= 64'h0;
            cur.req <= 64'h0;
            cur.isrA <= 64'h0;
            cur.isrB <= 64'h0;
            cur.pend <= 64'h0;
            cur.msgState <= MSG_IDLE;
            cur.msgVec <= 8'h00;
            cur.irqA <= 1'b0;
            cur.irqB <= 1'b0;
            cur.ack <= 1'b0;
            cur.rdata <= 32'h0;
        end else begin
            cur <= next_cur;
        end
    end

    // ********************************
    // Outputs
    // ********************************
    assign readdata = cur.rdata;
    // Pins come straight from flops, so they never glitch
    assign irq_out_a_n = ~cur.irqA;
    assign irq_out_b_n = ~cur.irqB;
    assign msgValid = (cur.msgState == MSG_SEND);
    assign msgVector = cur.msgVec;

endmodule

// >>> design/lowest_set_pick.sv
// Purpose: Finds the lowest set bit of a 64-bit pending vector
// Assumes: Purely combinational, used by the message sender
// Notes:   Lowest index wins when several sources rise together
`timescale 1ns/10ps
module lowest_set_pick (
    input wire logic [63:0] pending, // Bits awaiting a message
    output logic found,              // Any bit set
    output logic [5:0] index,        // Index of lowest set bit
    output logic [63:0] onehot       // That bit alone
);

    always_comb begin
        found = 1'b0;
        index = 6'h00;
        for (int i = 63; i >= 0; i--) begin
            if (pending[i]) begin
                found = 1'b1;
                index = 6'(i);
            end
        end
        onehot = found ? (64'h1 << index) : 64'h0;
    end

endmodule

// >>> verif/ht_host_model.sv
// Purpose: Far-side message receiver with a settable stall
// Assumes: Takes one vector per valid, ready is registered
// Notes: A stall of zero still costs one cycle, like a real flop
`timescale 1ns/10ps
module ht_host_model (
    input wire logic core_clk,         // Clock
    input wire logic rst_n,            // Reset, active low
    input wire logic msgValid,         // Message valid
    input wire logic [7:0] msgVector,  // Message vector
    input wire logic [3:0] stallCycles, // Cycles to hold off
    output logic msgReady,             // Message taken
    output logic [7:0] gotVector,      // Last vector taken
    output logic [7:0] gotCount        // Vectors taken
);
    logic [3:0] waitCnt;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            waitCnt <= 4'h0;
            msgReady <= 1'b0;
            gotVector <= 8'h00;
            gotCount <= 8'h00;
        end else if (msgValid && msgReady) begin
            msgReady <= 1'b0;
            waitCnt <= 4'h0;
            gotVector <= msgVector;
            gotCount <= gotCount + 8'h01;
        end else if (msgValid) begin
            if (waitCnt >= stallCycles) msgReady <= 1'b1;
            else waitCnt <= waitCnt + 4'h1;
        end
    end
endmodule

// >>> verif/irq_vec_assertions.sv
// Purpose: Port-level timing checks for irq_vector_status
// Assumes: One clock domain, reset asynchronous and active low
// Notes: Watches the block's outputs and also the bus, route and msgReady inputs
`timescale 1ns/10ps
module irq_vec_assertions (
    input wire logic core_clk,          // Clock
    input wire logic rst_n,             // Reset, active low
    input wire logic [9:0] address,     // Bus address
    input wire logic read,              // Bus read
    input wire logic write,             // Bus write
    input wire logic [31:0] readdata,   // Bus read data
    input wire logic waitrequest,       // Bus wait
    input wire logic [63:0] routeA,     // Route to output A
    input wire logic [63:0] routeB,     // Route to output B
    input wire logic irq_out_a_n,       // Line A, low
    input wire logic irq_out_b_n,       // Line B, low
    input wire logic msgValid,          // Message valid
    input wire logic [7:0] msgVector,   // Message vector
    input wire logic msgReady           // Message taken
);
    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    a_wait_one: assert property
        ((read || write) && waitrequest |=> !waitrequest)
        else $error("Bus wait longer than one cycle");
    a_wait_idle: assert property (!(read || write) |-> !waitrequest)
        else $error("Wait raised with no request");
    a_read_stands: assert property (!read |=> $stable(readdata))
        else $error("Read data changed without a read");
    a_unmapped_zero: assert property
        (read && !waitrequest && address == 10'h100 |-> readdata == 32'h0)
        else $error("Unmapped read not zero");
    a_pin_a_route: assert property
        (!irq_out_a_n |-> $past(|routeA))
        else $error("Line A low with nothing routed to it");
    a_pin_b_route: assert property
        (!irq_out_b_n |-> $past(|routeB))
        else $error("Line B low with nothing routed to it");
    a_msg_pins_high: assert property
        (msgValid |-> irq_out_a_n && irq_out_b_n)
        else $error("Line pin low in message mode");
    a_msg_hold: assert property
        (msgValid && !msgReady |=> msgValid && $stable(msgVector))
        else $error("Message dropped or changed before taken");
    a_msg_gap: assert property (msgValid && msgReady |=> !msgValid)
        else $error("No idle cycle after message taken");
endmodule
bind irq_vector_status irq_vec_assertions u_chk (.core_clk(core_clk),
    .rst_n(rst_n), .address(address), .read(read), .write(write),
    .readdata(readdata), .waitrequest(waitrequest), .routeA(routeA),
    .routeB(routeB), .irq_out_a_n(irq_out_a_n), .irq_out_b_n(irq_out_b_n),
    .msgValid(msgValid), .msgVector(msgVector), .msgReady(msgReady));

// >>> verif/irq_vector_status_tb_top.sv
// Purpose: Register, line and message tests of irq_vector_status
// Assumes: Avalon master waits for waitrequest low
// Notes: Wherever chkAll runs, every requested source is routed, so request = A | B
`timescale 1ns/10ps
module irq_vector_status_tb_top;
    import irq_vec_pkg::*;
    logic core_clk, rst_n, read, write, waitrequest;
    logic irq_out_a_n, irq_out_b_n, msgValid, msgReady;
    logic [9:0] address;
    logic [31:0] writedata, readdata, q;
    logic [3:0] byteenable, stallCycles;
    logic [63:0] srcReq, routeA, routeB;
    logic [52:0] upperPins;
    logic [7:0] msgVector, gotVector, gotCount;
    int nErrors = 0;
    int samplesChecked = 0;
    logic [9:0] ofs [16] = '{OFS_VEC_USB, OFS_VEC_TIMER, OFS_VEC_AUDIO,
        OFS_VEC_GPIO, OFS_ISR_A_LO, OFS_ISR_A_HI, OFS_ISR_B_LO, OFS_ISR_B_HI,
        OFS_REQ_LO, OFS_REQ_HI, OFS_ISR_LO, OFS_ISR_HI, OFS_POL_LO,
        OFS_POL_HI, OFS_CTRL, 10'h100};
    logic [31:0] rstv [4] = '{RST_VEC_USB, RST_VEC_TIMER, RST_VEC_AUDIO,
        RST_VEC_GPIO};

    irq_vector_status u_dut (.core_clk(core_clk), .rst_n(rst_n),
        .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
        .waitrequest(waitrequest), .srcReq(srcReq), .upperPins(upperPins),
        .routeA(routeA), .routeB(routeB), .irq_out_a_n(irq_out_a_n),
        .irq_out_b_n(irq_out_b_n), .msgValid(msgValid),
        .msgVector(msgVector), .msgReady(msgReady));
    ht_host_model u_host (.core_clk(core_clk), .rst_n(rst_n),
        .msgValid(msgValid), .msgVector(msgVector),
        .stallCycles(stallCycles), .msgReady(msgReady),
        .gotVector(gotVector), .gotCount(gotCount));

    // ****************************************
    // Tasks
    // ****************************************
    task automatic testDone();
        if (nErrors == 0 && samplesChecked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e,
        input logic [31:0] g);
        samplesChecked++;
        if (g !== e) begin
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
            nErrors++;
        end
    endtask
    // Request held until the edge that samples waitrequest low
    task automatic bus(input logic w, input logic [9:0] a,
        input logic [31:0] d, input logic [3:0] be);
        @(posedge core_clk);
        read <= !w;
        write <= w;
        address <= a;
        writedata <= d;
        byteenable <= be;
        @(posedge core_clk);
        while (waitrequest !== 1'b0) @(posedge core_clk);
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask
    task automatic rc(input logic [9:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0, 4'hF);
        chk($sformatf("reg %h", a), e, q);
    endtask
    task automatic chkAll(input logic [63:0] a, input logic [63:0] b);
        logic [63:0] c;
        c = a | b;
        rc(OFS_ISR_A_LO, a[31:0]);
        rc(OFS_ISR_A_HI, a[63:32]);
        rc(OFS_ISR_B_LO, b[31:0]);
        rc(OFS_ISR_B_HI, b[63:32]);
        rc(OFS_ISR_LO, c[31:0]);
        rc(OFS_ISR_HI, c[63:32]);
        rc(OFS_REQ_LO, c[31:0]);
        rc(OFS_REQ_HI, c[63:32]);
    endtask
    task automatic waitMsg(input logic [7:0] n, input logic [7:0] v);
        int k;
        k = 0;
        while (gotCount !== n && k < 60) begin
            @(posedge core_clk);
            k++;
        end
        chk("msgCount", n, gotCount);
        chk("msgVector", v, gotVector);
    endtask

    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    // Runs take about 230 cycles; far beyond that means a hang
    initial begin
        repeat (20000) @(posedge core_clk);
        nErrors++;
        testDone();
    end

    // ****************************************
    // Sequence
    // ****************************************
    initial begin
        rst_n = 1'b0;
        {read, write, address, writedata, byteenable} = '0;
        {srcReq, routeA, routeB, upperPins, stallCycles} = '0;
        repeat (12) @(posedge core_clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 16; i++)
            rc(ofs[i], i < 4 ? rstv[i] : 32'h0);
        bus(1'b1, OFS_VEC_TIMER, 32'hA1B2C3D4, 4'h8);
        rc(OFS_VEC_TIMER, 32'hA1565554);
        bus(1'b1, OFS_VEC_GPIO, 32'h11223344, 4'hF);
        rc(OFS_VEC_GPIO, 32'h11223344);
        bus(1'b1, OFS_ISR_A_LO, 32'hFFFFFFFF, 4'hF);
        bus(1'b1, OFS_REQ_LO, 32'hFFFFFFFF, 4'hF);
        rc(OFS_REQ_LO, 32'h0);
        // Routing kept one-hot by software
        srcReq[5] <= 1'b1;
        routeA[5] <= 1'b1;
        srcReq[40] <= 1'b1;
        routeB[40] <= 1'b1;
        chkAll(64'h20, 64'h100_0000_0000);
        chk("pinA", 1'b0, irq_out_a_n);
        chk("pinB", 1'b0, irq_out_b_n);
        routeA[5] <= 1'b0;
        routeB[5] <= 1'b1;
        chkAll(64'h0, 64'h100_0000_0020);
        chk("pinA", 1'b1, irq_out_a_n);
        srcReq <= '0;
        routeA[0] <= 1'b1;
        bus(1'b1, OFS_POL_LO, 32'h1, 4'hF);
        rc(OFS_POL_LO, 32'h1);
        chkAll(64'h1, 64'h0);
        srcReq[0] <= 1'b1;
        rc(OFS_REQ_LO, 32'h0);
        bus(1'b1, OFS_POL_LO, 32'h0, 4'hF);
        srcReq <= '0;
        upperPins[52] <= 1'b1;
        rc(OFS_REQ_HI, 32'h0800_0000);
        upperPins <= '0;
        srcReq[56] <= 1'b1;
        @(posedge core_clk);
        srcReq[56] <= 1'b0;
        rc(OFS_REQ_HI, 32'h0100_0000);
        bus(1'b1, OFS_REQ_HI, 32'h0100_0000, 4'hF);
        rc(OFS_REQ_HI, 32'h0);
        chk("msgCount", 8'h00, gotCount);
        bus(1'b1, OFS_CTRL, 32'h1, 4'hF);
        stallCycles <= 4'h3;
        srcReq[55] <= 1'b1;
        waitMsg(8'h01, 8'hA1);
        srcReq[60] <= 1'b1;
        upperPins[0] <= 1'b1;
        waitMsg(8'h02, RST_VEC_AUDIO[31:24]);
        waitMsg(8'h03, 8'h44);
        stallCycles <= 4'h0;
        srcReq[61] <= 1'b1;
        waitMsg(8'h04, 8'h33);
        // Line mode with GPIO as edge: a pulse must latch until cleared
        srcReq <= '0;
        upperPins <= '0;
        bus(1'b1, OFS_CTRL, 32'h2, 4'hF);
        routeB[63] <= 1'b1;
        srcReq[63] <= 1'b1;
        @(posedge core_clk);
        srcReq[63] <= 1'b0;
        rc(OFS_REQ_HI, 32'h8000_0000);
        chk("pinB", 1'b0, irq_out_b_n);
        bus(1'b1, OFS_REQ_HI, 32'h8000_0000, 4'h8);
        rc(OFS_REQ_HI, 32'h0);
        chk("pinB", 1'b1, irq_out_b_n);
        testDone();
    end
endmodule
